// ---- rsq_map.svh ----
// Purpose: Offsets, fields, reset values and timing counts of the reset sequencer
// Assumes: 32-bit APB, one aligned word per register
// Notes:   Byte addresses
`ifndef RSQ_MAP_SVH
`define RSQ_MAP_SVH

`define RSQ_OFF_STATUS    12'h000
`define RSQ_OFF_CTRL      12'h004
`define RSQ_OFF_IRQ_MASK  12'h008
`define RSQ_OFF_VECTOR    12'h00C
`define RSQ_OFF_STAGE     12'h010

`define RSQ_SRC_POWER_ON  0
`define RSQ_SRC_EXT_PIN   1
`define RSQ_SRC_WATCHDOG  2
`define RSQ_SRC_BROWNOUT  3
`define RSQ_SRC_DEBUG     4
`define RSQ_SRC_SOFTWARE  5
`define RSQ_NUM_SRC       6

`define RSQ_CTRL_SW_RESET 0
`define RSQ_CTRL_BOOTVEC  1

`define RSQ_RESET_VECTOR  16'h0000
`define RSQ_BOOT_VECTOR   16'h4000
`define RSQ_STAT_RESET    6'h01
`define RSQ_MASK_RESET    6'h00

// Stage lengths in cycles of pclk
`define RSQ_COUNT_DELAY   16'h0040
`define RSQ_OSC_START     16'h0020
`define RSQ_OSC_CAL       16'h0010

`endif

// ---- rsq_pkg.sv ----
// Purpose: Types of the reset sequencer
// Assumes: Constants live in rsq_map.svh
// Notes:   Types only
package rsq_pkg;

  typedef enum logic [2:0]
  {
    RSQ_HOLD,
    RSQ_COUNT,
    RSQ_OSC_UP,
    RSQ_CALIB,
    RSQ_RUN
  } rsq_stage_e;

  typedef struct packed
  {
    logic software;
    logic debug_interface_reset;
    logic brownout;
    logic watchdog;
    logic ext_pin;
    logic power_on;
  } rsq_src_s;

  typedef struct packed
  {
    logic        cpu_reset_n;
    logic        io_tristate;
    logic        osc_2mhz_sel;
    logic        pll_enable;
    logic        digital_frequency_locked_loop_enable;
    logic [15:0] reset_vector;
  } rsq_sys_s;

endpackage

// ---- rsq_reset_sequencer.sv ----
// Purpose: System reset combiner and restart sequencer with APB registers
// Assumes: Reset requests are asynchronous levels from analog detectors and pins
// Notes:   Reset assertion needs no clock; release is synchronised to pclk
//          Flags see the pins through two flip-flops; the hold itself never waits,
//          so a request shorter than one pclk cycle resets but may set no flag
//
// The APB interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "rsq_map.svh"

module rsq_reset_sequencer
  import rsq_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        por_req,
  input  wire logic        ext_pin_req,
  input  wire logic        watchdog_req,
  input  wire logic        brownout_req,
  input  wire logic        debug_interface_reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output rsq_sys_s         sys_out,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Request combining

  logic       sw_req;
  logic       boot_vec_sel;
  logic       any_req;
  logic       req_rst_n;
  logic       sync1_n;
  logic       sync2_n;
  rsq_src_s   src_now;

  assign src_now = '{software: sw_req, debug_interface_reset: debug_interface_reset,
                     brownout: brownout_req, watchdog: watchdog_req,
                     ext_pin: ext_pin_req, power_on: por_req};
  // Any active source, brownout covers low supply
  assign any_req   = |src_now;
  assign req_rst_n = presetn & ~any_req;

  // Release synchroniser; assertion stays asynchronous
  always_ff @(posedge pclk or negedge req_rst_n)
  begin
    if (!req_rst_n)
    begin
      sync1_n <= 1'b0;
      sync2_n <= 1'b0;
    end
    else
    begin
      sync1_n <= 1'b1;
      sync2_n <= sync1_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Restart stages; any request clears the stage back to hold
  // Release timing: two edges through the synchroniser, one in hold, then
  // the three stage counts; the core leaves reset one edge after run.
  // A request at any point pulls sync2_n low and the count starts over.

  rsq_stage_e  stage;
  rsq_stage_e  next_stage;
  logic [15:0] cnt;
  logic [15:0] next_cnt;
  logic [15:0] stage_len;
  logic        stage_done;

  assign stage_len  = (stage == RSQ_COUNT)  ? `RSQ_COUNT_DELAY :
                      (stage == RSQ_OSC_UP) ? `RSQ_OSC_START : `RSQ_OSC_CAL;
  assign stage_done = (cnt == stage_len - 16'h0001);

  always_comb
  begin
    next_stage = stage;
    next_cnt   = 16'h0000;
    case (stage)
      RSQ_HOLD:
        next_stage = RSQ_COUNT;
      RSQ_COUNT:
      begin
        if (stage_done)
          next_stage = RSQ_OSC_UP;
        else
          next_cnt = cnt + 16'h0001;
      end
      RSQ_OSC_UP:
      begin
        if (stage_done)
          next_stage = RSQ_CALIB;
        else
          next_cnt = cnt + 16'h0001;
      end
      RSQ_CALIB:
      begin
        if (stage_done)
          next_stage = RSQ_RUN;
        else
          next_cnt = cnt + 16'h0001;
      end
      RSQ_RUN:
        next_stage = RSQ_RUN;
      default:
        next_stage = RSQ_HOLD;
    endcase
  end

  // Stage register reset by the synchronised release, so a fresh request starts over
  always_ff @(posedge pclk or negedge sync2_n)
  begin
    if (!sync2_n)
    begin
      stage <= RSQ_HOLD;
      cnt   <= 16'h0000;
    end
    else
    begin
      stage <= next_stage;
      cnt   <= next_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers; status survives all resets except power-on
  // Word map: status (W1C flags), control (software request, boot vector
  // select), interrupt mask, current vector (read only), stage (read only).
  // Status and boot select sit on the power-on domain so that software can
  // tell after a restart what caused it; the mask follows sync2_n, the other registers here presetn.

  logic [5:0]  status;
  logic [5:0]  irq_mask;
  logic [4:0]  pin_now;
  logic [4:0]  pin_meta;
  logic [4:0]  pin_sync;
  logic [5:0]  src_flag;
  logic [5:0]  stat_clr;
  logic        wr_en;
  logic        rd_en;
  logic        hit_status;
  logic        hit_ctrl;
  logic        hit_mask;
  logic        hit_vector;
  logic        hit_stage;
  logic        hit_any;
  logic [31:0] rd_mux;
  logic [15:0] vector_now;
  logic        running;

  assign running    = (stage == RSQ_RUN);
  assign wr_en      = psel & penable & pwrite;
  assign rd_en      = psel & ~penable & ~pwrite;  // Setup cycle, data stands in access
  assign hit_status = (paddr == `RSQ_OFF_STATUS);
  assign hit_ctrl   = (paddr == `RSQ_OFF_CTRL);
  assign hit_mask   = (paddr == `RSQ_OFF_IRQ_MASK);
  assign hit_vector = (paddr == `RSQ_OFF_VECTOR);
  assign hit_stage  = (paddr == `RSQ_OFF_STAGE);
  assign hit_any    = hit_status | hit_ctrl | hit_mask | hit_vector | hit_stage;
  assign vector_now = boot_vec_sel ? `RSQ_BOOT_VECTOR : `RSQ_RESET_VECTOR;
  assign pin_now    = {debug_interface_reset, brownout_req, watchdog_req,
                       ext_pin_req, por_req};
  assign src_flag   = {sw_req, pin_sync};
  assign stat_clr   = (wr_en && hit_status) ? pwdata[5:0] : 6'h00;
  assign rd_mux     = hit_status ? {26'h0, status} :
                      hit_ctrl   ? {30'h0, boot_vec_sel, sw_req} :
                      hit_mask   ? {26'h0, irq_mask} :
                      hit_vector ? {16'h0, vector_now} :
                      hit_stage  ? {29'h0, stage} : 32'h0;

  // Flag synchroniser; pins are asynchronous to pclk and must not reach the flags raw
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_meta <= 5'h00;
      pin_sync <= 5'h00;
    end
    else
    begin
      pin_meta <= pin_now;
      pin_sync <= pin_meta;
    end
  end

  // Sticky flags; power-on alone clears, a new source set wins over W1C
  always_ff @(posedge pclk or posedge por_req)
  begin
    if (por_req)
      status <= `RSQ_STAT_RESET;
    else
      status <= (status & ~stat_clr) | src_flag;
  end

  // Software request is a one-cycle pulse; it feeds req_rst_n, so it must not
  // be cleared by the reset it raises, or the pulse would vanish unflagged
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sw_req <= 1'b0;
    else
      sw_req <= wr_en & hit_ctrl & pwdata[`RSQ_CTRL_SW_RESET];
  end

  // Mask returns to its reset value with every system reset
  always_ff @(posedge pclk or negedge sync2_n)
  begin
    if (!sync2_n)
      irq_mask <= `RSQ_MASK_RESET;
    else if (wr_en && hit_mask)
      irq_mask <= pwdata[5:0];
  end

  // Boot option survives non power-on resets
  always_ff @(posedge pclk or posedge por_req)
  begin
    if (por_req)
      boot_vec_sel <= 1'b0;
    else if (wr_en && hit_ctrl)
      boot_vec_sel <= pwdata[`RSQ_CTRL_BOOTVEC];
  end

  // APB answer in the access cycle; unmapped reads zero with error
  // pready, prdata and pslverr are all launched at the setup edge, so a
  // master finds them standing when it samples pready. Status may move
  // between setup and access; the read shows the value at setup.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      irq     <= 1'b0;
    end
    else
    begin
      prdata  <= rd_en ? rd_mux : 32'h0;
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~hit_any;
      irq     <= |(status & irq_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // System outputs; tristate and core hold are asynchronous on any request
  // The clock choice is held at its startup values in every state: this block
  // only guarantees the setting after reset; later changes belong to the
  // clock controller, which takes over once the core runs.

  always_ff @(posedge pclk or negedge req_rst_n)
  begin
    if (!req_rst_n)
    begin
      sys_out.cpu_reset_n  <= 1'b0;
      sys_out.io_tristate  <= 1'b1;
      sys_out.osc_2mhz_sel <= 1'b1;
      sys_out.pll_enable   <= 1'b0;
      sys_out.digital_frequency_locked_loop_enable  <= 1'b0;
      sys_out.reset_vector <= 16'h0000;
    end
    else
    begin
      sys_out.cpu_reset_n  <= running;
      sys_out.io_tristate  <= ~running;
      sys_out.osc_2mhz_sel <= 1'b1;
      sys_out.pll_enable   <= 1'b0;
      sys_out.digital_frequency_locked_loop_enable  <= 1'b0;
      sys_out.reset_vector <= vector_now;
    end
  end

  // RAM has no reset here; it is outside this block and kept intact
endmodule

// ---- rsq_reset_sequencer_assertions.sv ----
// Purpose: Port checks of the reset sequencer
// Assumes: One pclk domain, stages total 112 cycles
// Notes:   Bound from the bench top
`timescale 1ns/1ps
module rsq_reset_sequencer_assertions
  import rsq_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        por_req,
  input wire logic        ext_pin_req,
  input wire logic        watchdog_req,
  input wire logic        brownout_req,
  input wire logic        debug_interface_reset,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire rsq_sys_s    sys_out,
  input wire logic        irq
);
  logic       any_req;
  logic [7:0] cnt;
  assign any_req = por_req | ext_pin_req | watchdog_req | brownout_req | debug_interface_reset;
  // Cycles since last request; saturates so it never wraps into the window
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) cnt <= 8'h00;
    else if (any_req) cnt <= 8'h00;
    else if (cnt != 8'hFF) cnt <= cnt + 8'h01;
  ////////////////////////////////////////
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_req; any_req |-> !sys_out.cpu_reset_n && sys_out.io_tristate; endproperty
  a_req: assert property (p_req) else $error("core free during request");
  property p_tri; !sys_out.cpu_reset_n |-> sys_out.io_tristate; endproperty
  a_tri: assert property (p_tri) else $error("pins driven in reset");
  property p_osc;
    !sys_out.cpu_reset_n |-> sys_out.osc_2mhz_sel && !sys_out.pll_enable && !sys_out.digital_frequency_locked_loop_enable;
  endproperty
  a_osc: assert property (p_osc) else $error("clock setup wrong in reset");
  property p_vec; sys_out.reset_vector inside {16'h0000, 16'h4000}; endproperty
  a_vec: assert property (p_vec) else $error("bad vector");
  property p_early; cnt < 8'h70 |-> !sys_out.cpu_reset_n; endproperty
  a_early: assert property (p_early) else $error("released early");
  property p_late; cnt == 8'h8C |-> sys_out.cpu_reset_n && !sys_out.io_tristate; endproperty
  a_late: assert property (p_late) else $error("release missing");
  property p_sw;
    psel && penable && pready && pwrite && paddr == 12'h004 && pwdata[0]
      |-> ##[1:3] !sys_out.cpu_reset_n;
  endproperty
  a_sw: assert property (p_sw) else $error("software reset ignored");
  property p_rdy; psel && !penable |=> pready && penable; endproperty
  a_rdy: assert property (p_rdy) else $error("no answer in access cycle");
  property p_err; pslverr |-> pready && paddr > 12'h010; endproperty
  a_err: assert property (p_err) else $error("stray error");
  c_run: cover property ($rose(sys_out.cpu_reset_n));
  c_err: cover property (pslverr);
  c_irq: cover property (irq);
endmodule

// ---- rsq_src_model.sv ----
// Purpose: Reset request sources facing the sequencer
// Assumes: Levels change just after a rising edge
// Notes:   Bit order follows rsq_src_s
`timescale 1ns/1ps
module rsq_src_model
  import rsq_pkg::*;
(
  input  wire logic pclk,
  output rsq_src_s  req
);
  // Power-on stands from time zero, all other sources idle
  initial req = 6'h01;
  // Change one source level
  task automatic set(input int i, input logic v);
    @(posedge pclk);
    req[i] <= v;
  endtask
endmodule

// ---- rsq_reset_sequencer_tb_top.sv ----
// Purpose: Self-checking bench of the reset sequencer
// Assumes: APB answers in the access cycle
// Notes:   Rows hold source index and expected status
`timescale 1ns/1ps
module rsq_reset_sequencer_tb_top
  import rsq_pkg::*;
;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  rsq_sys_s    sys_out;
  rsq_src_s    req;
  int          failures;
  int          checked;
  int          n;
  logic [31:0] rd;
  logic        err;
  logic [8:0]  row [5] = '{9'h001, 9'h043, 9'h087, 9'h0CF, 9'h11F};
  rsq_src_model src (.pclk, .req);
  rsq_reset_sequencer uut (.pclk, .presetn, .por_req(req.power_on), .ext_pin_req(req.ext_pin),
    .watchdog_req(req.watchdog), .brownout_req(req.brownout),
    .debug_interface_reset(req.debug_interface_reset), .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .sys_out, .irq);
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      failures++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One APB transfer; request held until pready is sampled
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
    begin
      @(posedge pclk);
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Time the restart, then let the core settle
  task automatic wait_run();
    n = 0;
    while (sys_out.cpu_reset_n !== 1'b1 && n < 400)
    begin
      @(negedge pclk);
      n++;
    end
    chk(32'(n >= 112 && n < 400), 32'h1);
    repeat (30) @(posedge pclk);
  endtask
  // Pulse a source; hold must appear without a further edge
  task automatic hit(input int i);
    src.set(i, 1'b1);
    #1;
    chk({sys_out.cpu_reset_n, sys_out.io_tristate}, 32'h1);
    repeat (3) @(posedge pclk);
    src.set(i, 1'b0);
    wait_run();
  endtask
  task automatic complete_run();
    $display("failures=%0d checked=%0d", failures, checked);
    if (failures == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////
  initial
  begin
    #200000;
    failures++;
    complete_run();
  end
  initial
  begin
    failures = 0;
    checked = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    src.set(0, 1'b0);
    wait_run();
    // Each of the five pin sources in turn; flags accumulate
    foreach (row[k])
    begin
      hit(int'(row[k][8:6]));
      apb(0, 12'h000, 0, rd, err);
      chk(rd, {26'h0, row[k][5:0]});
    end
    apb(0, 12'h00C, 0, rd, err);
    chk(rd, 32'h0);
    apb(0, 12'h010, 0, rd, err);
    chk(rd, 32'h4);
    apb(0, 12'h020, 0, rd, err);
    chk({rd[30:0], err}, 32'h1);
    // Interrupt raised by mask, dropped by clearing the flag
    apb(1, 12'h008, 32'h2, rd, err);
    repeat (2) @(posedge pclk);
    chk(irq, 32'h1);
    apb(1, 12'h000, 32'h2, rd, err);
    repeat (2) @(posedge pclk);
    chk(irq, 32'h0);
    // Software reset with boot vector chosen
    apb(1, 12'h004, 32'h2, rd, err);
    apb(1, 12'h004, 32'h3, rd, err);
    repeat (3) @(posedge pclk);
    wait_run();
    chk(sys_out.reset_vector, 32'h4000);
    apb(0, 12'h000, 0, rd, err);
    chk(rd, 32'h3D);
    apb(0, 12'h008, 0, rd, err);
    chk(rd, 32'h0);
    // Second request in mid-sequence restarts the count
    src.set(1, 1'b1);
    repeat (3) @(posedge pclk);
    src.set(1, 1'b0);
    repeat (60) @(posedge pclk);
    hit(2);
    hit(0);
    apb(0, 12'h000, 0, rd, err);
    chk(rd, 32'h1);
    chk(sys_out.reset_vector, 32'h0);
    complete_run();
  end
endmodule
bind rsq_reset_sequencer rsq_reset_sequencer_assertions chk_i (.pclk, .presetn, .por_req,
  .ext_pin_req, .watchdog_req, .brownout_req, .debug_interface_reset, .psel, .penable,
  .pwrite, .paddr, .pwdata, .pready, .pslverr, .sys_out, .irq);
